// [rtl/irc_pkg.sv]
// Summary of operation
// - primary index: 16 bits, four nibbles
// - short primary compare: immediate against bits 7..0
// - masked single-cycle instruction: one no-op cycle
// - masked double-cycle instruction: two no-op cycles
// - masked relative branch: no-op, then PC+X+2
// - page-lock and release instructions never masked
// - interrupts held over compare and next instruction
// - long primary compare: 16 bits, 8 cycles
// - short secondary compare: immediate against bits 7..0
// - long secondary compare: 13 bits, 8 cycles
// - secondary index: 13 bits, bit 12 alone
// - immediate load writes all 13 secondary bits
// - nibble load; top part takes RAM bit 0
// - nibble store copies sub-register to RAM
// - backup area c0..ff, 16 sets, 4 cycles
// - whole-register restore and save, 13 bits
// - auto-increment secondary by 1, 2 or 4
package irc_pkg;
   localparam int PRI_W = 16;
   localparam int SEC_W = 13;
   localparam int NIB_W = 4;
   localparam int SHORT_W = 8;
   localparam int RAM_AW = 13;
   localparam int PC_W = 16;
   localparam int OP_W = 4;
   localparam int KIND_W = 2;
   localparam int CNT_W = 3;
   localparam int NOP_CNT_W = 8;
   localparam int NOP_CLKS_DEF = 4;
   localparam int LONG_CMP_CYCLES = 8;
   localparam int XFER_CYCLES = 4;
   localparam logic [2:0] LCMP_LOAD = 3'(LONG_CMP_CYCLES - 2);
   localparam logic [2:0] XFER_LOAD = 3'(XFER_CYCLES - 1);
   localparam logic [12:0] BACKUP_BASE = 13'h00c0;
   localparam logic [12:0] BACKUP_LAST = 13'h00ff;
   localparam logic [15:0] REL_PC_ADJ = 16'h0002;
   localparam logic [3:0] OP_OTHER = 4'h0;
   localparam logic [3:0] OP_PRI_IMM_LOAD = 4'h1;
   localparam logic [3:0] OP_PRI_SHORT_CMP = 4'h2;
   localparam logic [3:0] OP_PRI_LONG_CMP = 4'h3;
   localparam logic [3:0] OP_SEC_IMM_LOAD = 4'h4;
   localparam logic [3:0] OP_SEC_NIB_LOAD = 4'h5;
   localparam logic [3:0] OP_SEC_NIB_STORE = 4'h6;
   localparam logic [3:0] OP_SEC_RESTORE = 4'h7;
   localparam logic [3:0] OP_SEC_SAVE = 4'h8;
   localparam logic [3:0] OP_SEC_SHORT_CMP = 4'h9;
   localparam logic [3:0] OP_SEC_LONG_CMP = 4'ha;
   localparam logic [3:0] OP_SEC_INC = 4'hb;
   localparam logic [1:0] KIND_SINGLE = 2'h0;
   localparam logic [1:0] KIND_DOUBLE = 2'h1;
   localparam logic [1:0] KIND_RELATIVE = 2'h2;
   localparam logic [1:0] KIND_PAGE_LOCK = 2'h3;
   localparam logic [1:0] SEL_LOW = 2'h0;
   localparam logic [1:0] SEL_HIGH = 2'h1;
   localparam logic [1:0] SEL_UPPER = 2'h2;
   localparam logic [1:0] SEL_TOP = 2'h3;
   localparam logic [1:0] INC_CODE_ONE = 2'h0;
   localparam logic [1:0] INC_CODE_TWO = 2'h1;
   localparam logic [12:0] INC_ONE = 13'h0001;
   localparam logic [12:0] INC_TWO = 13'h0002;
   localparam logic [12:0] INC_FOUR = 13'h0004;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LCMP = 3'b001,
      ST_XFER = 3'b010,
      ST_NIB = 3'b011,
      ST_NOP = 3'b100,
      ST_REL = 3'b101
   } irc_state_t;

   // top part is bit 12 alone, upper RAM bits read as zero
   function automatic logic [3:0] irc_get_nib(input logic [12:0] v,
                                              input logic [1:0] sel);
      logic [3:0] r;
      r = 4'h0;
      unique case (sel)
         SEL_LOW: r = v[3:0];
         SEL_HIGH: r = v[7:4];
         SEL_UPPER: r = v[11:8];
         SEL_TOP: r = {3'h0, v[12]};
      endcase
      return r;
   endfunction

   function automatic logic [12:0] irc_put_nib(input logic [12:0] v,
                                               input logic [1:0] sel,
                                               input logic [3:0] d);
      logic [12:0] r;
      r = v;
      unique case (sel)
         SEL_LOW: r[3:0] = d;
         SEL_HIGH: r[7:4] = d;
         SEL_UPPER: r[11:8] = d;
         SEL_TOP: r[12] = d[0];
      endcase
      return r;
   endfunction
endpackage

// [rtl/irc_eq_cmp.sv]
`timescale 1ns/1ps
module irc_eq_cmp #(
   parameter int W = 16,
   parameter int SHORT_W = 8
) (
   // operands
   input wire logic [W-1:0] value,
   input wire logic [W-1:0] imm,
   // narrow compare of the low bits only
   input wire logic short_mode,
   // result
   output logic equal
);
   wire short_eq = value[SHORT_W-1:0] == imm[SHORT_W-1:0];
   wire full_eq = value == imm;

   assign equal = short_mode ? short_eq : full_eq;
endmodule

// [rtl/irc_down_cnt.sv]
`timescale 1ns/1ps
module irc_down_cnt #(
   parameter int W = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // control
   input wire logic load,
   input wire logic [W-1:0] value,
   // state
   output logic [W-1:0] count,
   output logic zero
);
   wire [W-1:0] next_count = load ? value :
                             (count != '0) ? count - 1'b1 : count;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign zero = count == '0;
endmodule

// [rtl/irc_index_regs.sv]
`timescale 1ns/1ps
module irc_index_regs #(
   parameter int NOP_CLKS = irc_pkg::NOP_CLKS_DEF
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic NRST,
   // instruction from the sequencer
   input wire logic INSTR_VALID,
   input wire logic [3:0] INSTR_OP,
   input wire logic [1:0] INSTR_KIND,
   input wire logic [15:0] INSTR_IMM,
   input wire logic [12:0] INSTR_ADDR,
   input wire logic [15:0] INSTR_PC,
   input wire logic INSTR_END,
   // sequencer status
   output logic BUSY,
   output logic DONE,
   output logic MASKED,
   output logic PC_LOAD,
   output logic [15:0] PC_TARGET,
   output logic IRQ_HOLD,
   // data ram
   output logic [12:0] RAM_ADDR,
   output logic RAM_RE,
   output logic RAM_WE,
   output logic [3:0] RAM_WDATA,
   input wire logic [3:0] RAM_RDATA,
   // index registers
   output logic [15:0] PRIMARY_INDEX,
   output logic [12:0] SECONDARY_INDEX
);
   localparam logic [7:0] NOP_ONE = 8'(NOP_CLKS - 1);
   localparam logic [7:0] NOP_TWO = 8'(2 * NOP_CLKS - 1);

   irc_pkg::irc_state_t state;
   irc_pkg::irc_state_t next_state;
   logic [15:0] pri;
   logic [12:0] sec;
   logic [12:0] shadow;
   logic [12:0] next_shadow;
   logic [15:0] lcmp_imm;
   logic lcmp_pri;
   logic [3:0] held_op;
   logic [1:0] held_sel;
   logic mask_pending;
   logic rel_pending;
   logic follow;
   logic done;
   logic masked;
   logic pc_load;
   logic [15:0] pc_target;
   logic irq_hold;
   logic [12:0] ram_addr;
   logic ram_re;
   logic ram_we;
   logic [3:0] ram_wdata;
   logic [2:0] op_count;
   logic op_zero;
   logic nop_zero;
   logic pri_eq;
   logic sec_eq;

   // decode of the instruction being offered
   wire accept = INSTR_VALID && state == irc_pkg::ST_IDLE;
   wire take_mask = accept && mask_pending &&
                    INSTR_KIND != irc_pkg::KIND_PAGE_LOCK;
   wire exec = accept && !take_mask;
   wire is_op_pri_imm = INSTR_OP == irc_pkg::OP_PRI_IMM_LOAD;
   wire is_op_pri_short = INSTR_OP == irc_pkg::OP_PRI_SHORT_CMP;
   wire is_op_pri_long = INSTR_OP == irc_pkg::OP_PRI_LONG_CMP;
   wire is_op_sec_imm = INSTR_OP == irc_pkg::OP_SEC_IMM_LOAD;
   wire is_op_nib_load = INSTR_OP == irc_pkg::OP_SEC_NIB_LOAD;
   wire is_op_nib_store = INSTR_OP == irc_pkg::OP_SEC_NIB_STORE;
   wire is_op_restore = INSTR_OP == irc_pkg::OP_SEC_RESTORE;
   wire is_op_save = INSTR_OP == irc_pkg::OP_SEC_SAVE;
   wire is_op_sec_short = INSTR_OP == irc_pkg::OP_SEC_SHORT_CMP;
   wire is_op_sec_long = INSTR_OP == irc_pkg::OP_SEC_LONG_CMP;
   wire is_op_inc = INSTR_OP == irc_pkg::OP_SEC_INC;
   wire is_short_cmp = is_op_pri_short || is_op_sec_short;
   wire is_long_cmp = is_op_pri_long || is_op_sec_long;
   wire take_cmp = exec && (is_short_cmp || is_long_cmp);
   wire take_xfer = exec && (is_op_restore || is_op_save);
   wire take_nib = exec && (is_op_nib_load || is_op_nib_store);
   wire single_done = exec && (is_op_pri_imm || is_op_sec_imm ||
                               is_op_inc || is_short_cmp);

   // compares; the long form runs on the captured immediate
   wire in_lcmp = state == irc_pkg::ST_LCMP;
   wire [15:0] pri_cmp_imm = in_lcmp ? lcmp_imm : INSTR_IMM;
   wire [12:0] sec_cmp_imm = in_lcmp ? lcmp_imm[12:0] : INSTR_IMM[12:0];
   wire short_eq = is_op_pri_short ? pri_eq : sec_eq;
   wire long_eq = lcmp_pri ? pri_eq : sec_eq;
   wire lcmp_end = in_lcmp && op_zero;

   // backup area: set number picks four nibbles from base
   wire [12:0] set_base = irc_pkg::BACKUP_BASE +
                          {7'h00, INSTR_IMM[3:0], 2'b00};
   wire [1:0] xfer_idx = 2'(irc_pkg::XFER_LOAD - op_count);
   wire [1:0] xfer_next = 2'(xfer_idx + 2'h1);
   wire xfer_end = state == irc_pkg::ST_XFER && op_zero;
   wire restoring = held_op == irc_pkg::OP_SEC_RESTORE;
   wire nib_loading = held_op == irc_pkg::OP_SEC_NIB_LOAD;

   // auto-increment step
   wire [12:0] inc_step = (INSTR_IMM[1:0] == irc_pkg::INC_CODE_ONE) ?
                          irc_pkg::INC_ONE :
                          (INSTR_IMM[1:0] == irc_pkg::INC_CODE_TWO) ?
                          irc_pkg::INC_TWO : irc_pkg::INC_FOUR;

   // no-op timing of a masked instruction
   wire [7:0] nop_len = (INSTR_KIND == irc_pkg::KIND_DOUBLE) ?
                        NOP_TWO : NOP_ONE;
   wire nop_end = state == irc_pkg::ST_NOP && nop_zero;
   wire mask_end = (nop_end && !rel_pending) ||
                   state == irc_pkg::ST_REL;
   wire [15:0] rel_target = 16'(INSTR_PC + INSTR_IMM +
                                irc_pkg::REL_PC_ADJ);
   wire [2:0] op_load_val = take_xfer ? irc_pkg::XFER_LOAD :
                            irc_pkg::LCMP_LOAD;
   wire op_load = take_xfer || (exec && is_long_cmp);

   irc_eq_cmp #(.W(irc_pkg::PRI_W), .SHORT_W(irc_pkg::SHORT_W)) u_pri_cmp (
      .value(pri),
      .imm(pri_cmp_imm),
      .short_mode(!in_lcmp),
      .equal(pri_eq)
   );

   // only the low 13 immediate bits ever reach the secondary compare
   irc_eq_cmp #(.W(irc_pkg::SEC_W), .SHORT_W(irc_pkg::SHORT_W)) u_sec_cmp (
      .value(sec),
      .imm(sec_cmp_imm),
      .short_mode(!in_lcmp),
      .equal(sec_eq)
   );

   irc_down_cnt #(.W(irc_pkg::CNT_W)) u_op_cnt (
      .clk(CORE_CLK),
      .nrst(NRST),
      .load(op_load),
      .value(op_load_val),
      .count(op_count),
      .zero(op_zero)
   );

   irc_down_cnt #(.W(irc_pkg::NOP_CNT_W)) u_nop_cnt (
      .clk(CORE_CLK),
      .nrst(NRST),
      .load(take_mask),
      .value(nop_len),
      .count(),
      .zero(nop_zero)
   );

   // restore gathers nibbles in a shadow, committed all at once
   always_comb begin
      next_shadow = shadow;
      if (state == irc_pkg::ST_XFER && restoring) begin
         next_shadow = irc_pkg::irc_put_nib(shadow, xfer_idx,
                                            RAM_RDATA);
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         irc_pkg::ST_IDLE: begin
            if (take_mask) begin
               next_state = irc_pkg::ST_NOP;
            end else if (exec && is_long_cmp) begin
               next_state = irc_pkg::ST_LCMP;
            end else if (take_xfer) begin
               next_state = irc_pkg::ST_XFER;
            end else if (take_nib) begin
               next_state = irc_pkg::ST_NIB;
            end
         end
         irc_pkg::ST_LCMP: begin
            if (op_zero) begin
               next_state = irc_pkg::ST_IDLE;
            end
         end
         irc_pkg::ST_XFER: begin
            if (op_zero) begin
               next_state = irc_pkg::ST_IDLE;
            end
         end
         irc_pkg::ST_NIB: begin
            next_state = irc_pkg::ST_IDLE;
         end
         irc_pkg::ST_NOP: begin
            if (nop_zero) begin
               next_state = rel_pending ? irc_pkg::ST_REL :
                            irc_pkg::ST_IDLE;
            end
         end
         irc_pkg::ST_REL: begin
            next_state = irc_pkg::ST_IDLE;
         end
         default: begin
            next_state = irc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         state <= irc_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // index registers; a masked slot never reaches these paths
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         pri <= '0;
         sec <= '0;
         shadow <= '0;
      end else begin
         shadow <= next_shadow;
         if (exec && is_op_pri_imm) begin
            pri <= INSTR_IMM;
         end
         if (exec && is_op_sec_imm) begin
            sec <= INSTR_IMM[12:0];
         end else if (exec && is_op_inc) begin
            sec <= 13'(sec + inc_step);
         end else if (take_xfer && is_op_save) begin
            shadow <= sec;
         end else if (xfer_end && restoring) begin
            sec <= next_shadow;
         end else if (state == irc_pkg::ST_NIB && nib_loading) begin
            sec <= irc_pkg::irc_put_nib(sec, held_sel, RAM_RDATA);
         end
      end
   end

   // data ram port; read data are taken while the read strobe is high
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         ram_addr <= '0;
         ram_re <= 1'b0;
         ram_we <= 1'b0;
         ram_wdata <= '0;
      end else if (take_xfer) begin
         ram_addr <= set_base;
         ram_re <= is_op_restore;
         ram_we <= is_op_save;
         ram_wdata <= irc_pkg::irc_get_nib(sec, irc_pkg::SEL_LOW);
      end else if (take_nib) begin
         ram_addr <= INSTR_ADDR;
         ram_re <= is_op_nib_load;
         ram_we <= is_op_nib_store;
         ram_wdata <= irc_pkg::irc_get_nib(sec, INSTR_IMM[1:0]);
      end else if (state == irc_pkg::ST_XFER && !op_zero) begin
         ram_addr <= 13'(ram_addr + 13'h0001);
         ram_wdata <= irc_pkg::irc_get_nib(shadow, xfer_next);
      end else begin
         ram_re <= 1'b0;
         ram_we <= 1'b0;
      end
   end

   // operation bookkeeping
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         lcmp_imm <= '0;
         lcmp_pri <= 1'b0;
         held_op <= irc_pkg::OP_OTHER;
         held_sel <= irc_pkg::SEL_LOW;
         done <= 1'b0;
      end else begin
         done <= single_done || lcmp_end || xfer_end ||
                 state == irc_pkg::ST_NIB;
         if (exec) begin
            lcmp_imm <= INSTR_IMM;
            lcmp_pri <= is_op_pri_long;
            held_op <= INSTR_OP;
            held_sel <= INSTR_IMM[1:0];
         end
      end
   end

   // match flag: a new match outranks the clear by the next instruction
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         mask_pending <= 1'b0;
      end else if (exec && is_short_cmp) begin
         mask_pending <= short_eq;
      end else if (lcmp_end) begin
         mask_pending <= long_eq;
      end else if (accept) begin
         mask_pending <= 1'b0;
      end
   end

   // masked slot: no-op cycles, then the relative target if any
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         masked <= 1'b0;
         rel_pending <= 1'b0;
         pc_load <= 1'b0;
         pc_target <= '0;
      end else begin
         pc_load <= nop_end && rel_pending;
         if (take_mask) begin
            masked <= 1'b1;
            rel_pending <= INSTR_KIND == irc_pkg::KIND_RELATIVE;
            pc_target <= rel_target;
         end else if (nop_end) begin
            masked <= 1'b0;
         end
      end
   end

   // interrupts wait for the compare and the slot behind it
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         irq_hold <= 1'b0;
         follow <= 1'b0;
      end else if (take_cmp) begin
         irq_hold <= 1'b1;
         follow <= 1'b0;
      end else if (follow && (mask_end || INSTR_END)) begin
         irq_hold <= 1'b0;
         follow <= 1'b0;
      end else if (accept && irq_hold) begin
         follow <= 1'b1;
      end
   end

   assign BUSY = state != irc_pkg::ST_IDLE;
   assign DONE = done;
   assign MASKED = masked;
   assign PC_LOAD = pc_load;
   assign PC_TARGET = pc_target;
   assign IRQ_HOLD = irq_hold;
   assign RAM_ADDR = ram_addr;
   assign RAM_RE = ram_re;
   assign RAM_WE = ram_we;
   assign RAM_WDATA = ram_wdata;
   assign PRIMARY_INDEX = pri;
   assign SECONDARY_INDEX = sec;

   // checks
   logic [7:0] mask_len;
   logic [15:0] exp_target;
   logic exp_double;

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         mask_len <= '0;
         exp_target <= '0;
         exp_double <= 1'b0;
      end else begin
         mask_len <= masked ? 8'(mask_len + 8'h01) : 8'h00;
         if (take_mask) begin
            // target kept apart from the pc_target capture path
            exp_target <= 16'(INSTR_PC + INSTR_IMM + irc_pkg::REL_PC_ADJ);
            exp_double <= INSTR_KIND == irc_pkg::KIND_DOUBLE;
         end
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   sequence s_lcmp_busy;
      BUSY [*7] ##1 (!BUSY && DONE);
   endsequence

   sequence s_four_reads;
      RAM_RE [*4] ##1 !RAM_RE;
   endsequence

   property p_short_match;
      exec && is_op_pri_short && pri[7:0] == INSTR_IMM[7:0] |=> mask_pending;
   endproperty
   a_short_match: assert property (p_short_match)
      else $error("short primary match did not arm masking");

   property p_single_nop;
      $fell(MASKED) && !exp_double |-> mask_len == 8'(NOP_CLKS);
   endproperty
   a_single_nop: assert property (p_single_nop)
      else $error("single slot no-op length wrong");

   property p_double_nop;
      $fell(MASKED) && exp_double |-> mask_len == 8'(2 * NOP_CLKS);
   endproperty
   a_double_nop: assert property (p_double_nop)
      else $error("double slot no-op length wrong");

   property p_rel_target;
      take_mask && INSTR_KIND == irc_pkg::KIND_RELATIVE
         |-> ##[1:300] (PC_LOAD && PC_TARGET == exp_target);
   endproperty
   a_rel_target: assert property (p_rel_target)
      else $error("relative target not loaded");

   property p_page_lock;
      accept && mask_pending && INSTR_KIND == irc_pkg::KIND_PAGE_LOCK
         |=> !MASKED && !BUSY;
   endproperty
   a_page_lock: assert property (p_page_lock)
      else $error("page lock instruction was masked");

   property p_irq_hold;
      take_cmp |=> IRQ_HOLD until_with (follow && (mask_end || INSTR_END));
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt hold dropped early");

   property p_lcmp_time;
      exec && is_op_pri_long |=> s_lcmp_busy;
   endproperty
   a_lcmp_time: assert property (p_lcmp_time)
      else $error("long compare not eight cycles");

   property p_sec_long;
      exec && is_op_sec_long && sec == INSTR_IMM[12:0] |-> ##8 mask_pending;
   endproperty
   a_sec_long: assert property (p_sec_long)
      else $error("long secondary match missed");

   property p_restore;
      take_xfer && is_op_restore |=> s_four_reads;
   endproperty
   a_restore: assert property (p_restore)
      else $error("restore not four reads");

   property p_area;
      state == irc_pkg::ST_XFER |-> RAM_ADDR >= irc_pkg::BACKUP_BASE &&
                                    RAM_ADDR <= irc_pkg::BACKUP_LAST;
   endproperty
   a_area: assert property (p_area)
      else $error("backup access outside area");

   property p_inc;
      exec && is_op_inc |=> sec == 13'($past(sec) + $past(inc_step));
   endproperty
   a_inc: assert property (p_inc)
      else $error("auto-increment wrong");

   property p_masked_still;
      MASKED |=> $stable(sec) && $stable(pri) && !RAM_WE;
   endproperty
   a_masked_still: assert property (p_masked_still)
      else $error("state changed in a masked slot");
endmodule

// [test/irc_ram_model.sv]
`timescale 1ns/1ps
module irc_ram_model (
   // port from the block
   input wire logic clk,
   input wire logic [12:0] addr,
   input wire logic re,
   input wire logic we,
   input wire logic [3:0] wdata,
   output logic [3:0] rdata
);
   logic [3:0] mem [0:8191];
   // unread cycles show the inverse, never a stale value
   assign rdata = re ? mem[addr] : ~mem[addr];
   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule

// [test/index_register_compare_mask_bench.sv]
`timescale 1ns/1ps
module index_register_compare_mask_bench;
   localparam int NC = 2;
   logic CORE_CLK = 1'b0;
   logic NRST = 1'b0;
   logic INSTR_VALID = 1'b0;
   logic INSTR_END = 1'b0;
   logic [3:0] INSTR_OP = 4'h0;
   logic [1:0] INSTR_KIND = 2'h0;
   logic [15:0] INSTR_IMM = 16'h0000;
   logic [12:0] INSTR_ADDR = 13'h0000;
   logic [15:0] INSTR_PC = 16'h0000;
   logic BUSY, DONE, MASKED, PC_LOAD, IRQ_HOLD, RAM_RE, RAM_WE;
   logic [15:0] PC_TARGET, PRIMARY_INDEX, pri, v, pt, im, x;
   logic [12:0] RAM_ADDR, SECONDARY_INDEX, sec;
   logic [3:0] RAM_WDATA, RAM_RDATA, op;
   int bad_count = 0;
   int n_checks = 0;
   int seed = 55;
   int dn, mk, pl, p;
   bit hit;
   always #20 CORE_CLK = ~CORE_CLK;
   irc_index_regs #(.NOP_CLKS(NC)) DUT (.CORE_CLK(CORE_CLK), .NRST(NRST),
      .INSTR_VALID(INSTR_VALID), .INSTR_OP(INSTR_OP),
      .INSTR_KIND(INSTR_KIND), .INSTR_IMM(INSTR_IMM),
      .INSTR_ADDR(INSTR_ADDR), .INSTR_PC(INSTR_PC), .INSTR_END(INSTR_END),
      .BUSY(BUSY), .DONE(DONE), .MASKED(MASKED), .PC_LOAD(PC_LOAD),
      .PC_TARGET(PC_TARGET), .IRQ_HOLD(IRQ_HOLD), .RAM_ADDR(RAM_ADDR),
      .RAM_RE(RAM_RE), .RAM_WE(RAM_WE), .RAM_WDATA(RAM_WDATA),
      .RAM_RDATA(RAM_RDATA), .PRIMARY_INDEX(PRIMARY_INDEX),
      .SECONDARY_INDEX(SECONDARY_INDEX));
   irc_ram_model ram (.clk(CORE_CLK), .addr(RAM_ADDR), .re(RAM_RE),
      .we(RAM_WE), .wdata(RAM_WDATA), .rdata(RAM_RDATA));
   function automatic logic [12:0] put(input logic [12:0] r, input int s,
                                       input logic [3:0] d);
      logic [15:0] w;
      w = {3'h0, r};
      w[4*s +: 4] = d;
      return w[12:0];
   endfunction
   function automatic logic [3:0] get(input logic [12:0] r, input int s);
      return 4'({3'h0, r} >> (4 * s));
   endfunction
   function automatic logic [12:0] ba(input logic [3:0] s, input int i);
      return 13'h0c0 + 13'(4 * s + i);
   endfunction
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      n_checks++;
      if (e !== s) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one instruction, then an end pulse unless it was masked
   task automatic run(input logic [3:0] o, input logic [1:0] k,
                      input logic [15:0] i, input logic [12:0] a);
      @(posedge CORE_CLK);
      #1;
      INSTR_VALID = 1'b1;
      INSTR_OP = o;
      INSTR_KIND = k;
      INSTR_IMM = i;
      INSTR_ADDR = a;
      INSTR_PC = pt;
      @(posedge CORE_CLK);
      #1;
      INSTR_VALID = 1'b0;
      dn = 0;
      mk = 0;
      pl = 0;
      for (int n = 1; n < 60; n++) begin
         if (DONE === 1'b1) dn = n;
         if (MASKED === 1'b1) mk++;
         if (PC_LOAD === 1'b1) pl = n;
         if (BUSY !== 1'b1 && MASKED !== 1'b1) break;
         @(posedge CORE_CLK);
         #1;
      end
      INSTR_END = (mk == 0);
      @(posedge CORE_CLK);
      #1;
      INSTR_END = 1'b0;
      repeat (2) @(posedge CORE_CLK);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #(40 * 40000);
      bad_count++;
      summarize();
   end
   initial begin
      pt = 16'h0000;
      repeat (2) @(posedge CORE_CLK);
      #1;
      NRST = 1'b1;
      chk("flags", 16'h0, {9'h0, BUSY, DONE, MASKED, PC_LOAD, IRQ_HOLD,
          RAM_RE, RAM_WE});
      chk("primary", 16'h0, PRIMARY_INDEX);
      chk("secondary", 16'h0, 16'(SECONDARY_INDEX));
      $display("test reset done");
      repeat (4) begin
         v = 16'($random(seed));
         run(irc_pkg::OP_PRI_IMM_LOAD, 2'h0, v, 13'h0);
         chk("primary", v, PRIMARY_INDEX);
         sec = 13'(~v);
         run(irc_pkg::OP_SEC_IMM_LOAD, 2'h0, ~v, 13'h0);
         chk("secondary", 16'(sec), 16'(SECONDARY_INDEX));
      end
      pri = v;
      $display("test loads done");
      for (int s = 0; s < 4; s++) begin
         v = 16'($random(seed));
         ram.mem[v[12:0]] = v[15:12];
         run(irc_pkg::OP_SEC_NIB_LOAD, 2'h0, 16'(s), v[12:0]);
         sec = put(sec, s, v[15:12]);
         chk("nib load", 16'(sec), 16'(SECONDARY_INDEX));
         run(irc_pkg::OP_SEC_NIB_STORE, 2'h0, 16'(s), 13'h1000 + 13'(s));
         chk("nib store", 16'(get(sec, s)),
             16'(ram.mem[13'h1000 + 13'(s)]));
      end
      $display("test nibbles done");
      repeat (3) begin
         v = 16'($random(seed));
         for (int i = 0; i < 4; i++) begin
            ram.mem[ba(v[3:0], i)] = 4'($random(seed));
         end
         sec = {ram.mem[ba(v[3:0], 3)][0], ram.mem[ba(v[3:0], 2)],
                ram.mem[ba(v[3:0], 1)], ram.mem[ba(v[3:0], 0)]};
         run(irc_pkg::OP_SEC_RESTORE, 2'h0, {12'h0, v[3:0]}, 13'h0);
         chk("restore cycles", 16'h5, 16'(dn));
         chk("restore", 16'(sec), 16'(SECONDARY_INDEX));
         sec = ~sec;
         run(irc_pkg::OP_SEC_IMM_LOAD, 2'h0, 16'(sec), 13'h0);
         run(irc_pkg::OP_SEC_SAVE, 2'h0, {12'h0, v[7:4]}, 13'h0);
         for (int i = 0; i < 4; i++) begin
            chk("save", 16'(get(sec, i)),
                16'(ram.mem[ba(v[7:4], i)]));
         end
      end
      $display("test backup done");
      sec = 13'h1ffe;
      run(irc_pkg::OP_SEC_IMM_LOAD, 2'h0, 16'(sec), 13'h0);
      for (int c = 0; c < 4; c++) begin
         run(irc_pkg::OP_SEC_INC, 2'h0, 16'(c), 13'h0);
         sec = sec + (c == 0 ? 13'h1 : c == 1 ? 13'h2 : 13'h4);
         chk("increment", 16'(sec), 16'(SECONDARY_INDEX));
      end
      $display("test increment done");
      for (int j = 0; j < 4; j++) begin
         for (int k = 0; k < 4; k++) begin
            for (int m = 0; m < 2; m++) begin
               v = 16'($random(seed));
               op = j == 0 ? irc_pkg::OP_PRI_SHORT_CMP :
                    j == 1 ? irc_pkg::OP_PRI_LONG_CMP :
                    j == 2 ? irc_pkg::OP_SEC_SHORT_CMP :
                    irc_pkg::OP_SEC_LONG_CMP;
               im = j == 0 ? {v[15:8], pri[7:0]} : j == 1 ? pri :
                    j == 2 ? {v[15:8], sec[7:0]} : {v[15:13], sec};
               p = int'(v) % (j == 1 ? 16 : j == 3 ? 13 : 8);
               if (m == 0) im = im ^ (16'h1 << p);
               run(op, 2'h0, im, 13'h0);
               chk("compare cycles", j[0] ? 16'h8 : 16'h1,
                   16'(dn));
               chk("hold", 16'h1, 16'(IRQ_HOLD));
               pt = 16'($random(seed));
               x = 16'($random(seed));
               hit = (m == 1) && (k != 3);
               run(irc_pkg::OP_SEC_INC, 2'(k), x, 13'h0);
               chk("nop cycles", hit ? 16'(k == 1 ? 2 * NC : NC) : 16'h0,
                   16'(mk));
               if (!hit) sec = sec + (x[1:0] == 2'h0 ? 13'h1 :
                                      x[1:0] == 2'h1 ? 13'h2 : 13'h4);
               chk("masked regs", 16'(sec), 16'(SECONDARY_INDEX));
               chk("pc load", (hit && k == 2) ? 16'(NC + 1) : 16'h0,
                   16'(pl));
               if (hit && k == 2) begin
                  chk("target", pt + x + 16'h2, PC_TARGET);
               end
               chk("hold", 16'h0, 16'(IRQ_HOLD));
            end
         end
      end
      $display("test compare done");
      summarize();
   end
endmodule
